// ==== design/hcl_pkg.sv ====
// Constants shared by the check capture, length counter and loopback block
package hcl_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned TAG_W = 2;
	localparam int unsigned WORD_W = DATA_W + TAG_W;
	localparam int unsigned BUF_DEPTH = 2;
	localparam int unsigned HOLD_DEPTH = 3;

	////////////////////////////////////////////////////////////////////////
	// Register offsets on the parallel port
	localparam logic [7:0] RX_CHECK_HIGH_BYTE_ADDR = 8'h18;
	localparam logic [7:0] RX_CHECK_LOW_BYTE_ADDR = 8'h19;
	localparam logic [7:0] TX_PACKET_LENGTH_COUNTER_ADDR = 8'h1a;
	localparam logic [7:0] LINK_TEST_CONTROL_ADDR = 8'h1b;
	localparam logic [7:0] FIFO_DATA_ADDR = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// Test control field positions
	localparam int unsigned LINK_SOFT_RESET_BIT = 7;
	localparam int unsigned RX_TO_TX_LOOPBACK_BIT = 6;
	localparam int unsigned FIFO_TEST_BIT = 2;
	localparam int unsigned TX_TO_RX_LOOPBACK_BIT = 0;

	// Tag positions inside a FIFO word, above the data byte
	localparam int unsigned PACKET_END_TAG_POS = 0;
	localparam int unsigned FRAME_ABORT_TAG_POS = 1;

	////////////////////////////////////////////////////////////////////////
	// Values after reset, plus the full hold count and the last count value
	localparam logic [7:0] LINK_TEST_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TX_LENGTH_COUNT_RESET = 8'h00;
	localparam logic [7:0] RX_CHECK_RESET = 8'h00;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;
	localparam logic [1:0] HOLD_COUNT_RESET = 2'h0;
	localparam logic [1:0] HOLD_COUNT_FULL = 2'h3;
	localparam logic [7:0] TX_LENGTH_LAST = 8'h01;
endpackage

// ==== design/hcl_stream_if.sv ====
// Valid/ready word stream between the block and its buffers
`timescale 1ns/10ps
interface hcl_stream_if #(
	parameter int unsigned WIDTH = 10
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ==== design/hcl_pair_buffer.sv ====
// Small circular buffer with valid/ready on both sides
`timescale 1ns/10ps
module hcl_pair_buffer #(
	parameter int unsigned WIDTH = hcl_pkg::WORD_W,
	parameter int unsigned DEPTH = hcl_pkg::BUF_DEPTH
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Streams
	hcl_stream_if.snk in_if,
	hcl_stream_if.src out_if
);
	localparam int unsigned PTR_W = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
		$error("hcl_pair_buffer: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
	logic [WIDTH-1:0] mem_next [0:DEPTH-1];
	logic [PTR_W:0] wr_ptr_reg;
	logic [PTR_W:0] wr_ptr_next;
	logic [PTR_W:0] rd_ptr_reg;
	logic [PTR_W:0] rd_ptr_next;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) && (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	// Both handshakes drop with the enable so no word is taken or handed on twice
	assign in_if.ready = !full && ce_i;
	assign out_if.valid = !empty && ce_i;
	assign out_if.data = mem_reg[rd_ptr_reg[PTR_W-1:0]];
	assign push = in_if.valid && !full;
	assign pop = out_if.ready && !empty;

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (push) begin
			mem_next[wr_ptr_reg[PTR_W-1:0]] = in_if.data;
		end
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (ce_i) begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			mem_reg <= mem_next;
		end
	end
endmodule

// ==== design/hcl_crc_count_loopback.sv ====
// Receive check capture, transmit length counter and test/loopback control
//
// Behaviour
// - Readable byte holds high received check bits
// - Readable byte holds low received check bits
// - Check bytes kept as sent, not inverted
// - Check bytes refresh only at packet end
// - Count of one tags next write end
// - Counter decrements after each transmit write, holds at zero
// - Auto repeat reloads length after tagged end
// - Soft reset bit holds controller in reset
// - Soft reset clears after two zero writes
// - Receive loopback copies data into transmit path
// - Looped data sent like host data, any check
// - FIFO test swaps host write and read paths
// - FIFO test passes tags both directions
// - Transmit loopback feeds transmit stream to receiver
`timescale 1ns/10ps
module hcl_crc_count_loopback #(
	parameter int unsigned DATA_WIDTH = hcl_pkg::DATA_W,
	parameter int unsigned BUFFER_DEPTH = hcl_pkg::BUF_DEPTH
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Parallel register port
	input wire logic cs_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic [1:0] fifo_tag_readback_o,
	output logic host_wait_o,
	// Loose control bits kept in other registers
	input wire logic auto_repeat_i,
	input wire logic packet_end_tag_i,
	input wire logic frame_abort_tag_i,
	// Controller-wide state
	output logic link_soft_reset_o,
	// Received byte stream from the deframer
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_last_i,
	input wire logic rx_abort_i,
	output logic rx_ready_o,
	// Transmit FIFO write and read ports
	output logic txf_wr_valid_o,
	output logic [7:0] txf_wr_data_o,
	output logic [1:0] txf_wr_tags_o,
	input wire logic txf_wr_ready_i,
	output logic txf_rd_o,
	input wire logic [7:0] txf_rd_data_i,
	input wire logic [1:0] txf_rd_tags_i,
	// Receive FIFO write and read ports
	output logic rxf_wr_valid_o,
	output logic [7:0] rxf_wr_data_o,
	output logic [1:0] rxf_wr_tags_o,
	input wire logic rxf_wr_ready_i,
	output logic rxf_rd_o,
	input wire logic [7:0] rxf_rd_data_i,
	input wire logic [1:0] rxf_rd_tags_i,
	// Serial streams
	input wire logic tx_serial_i,
	input wire logic line_rx_i,
	output logic rx_serial_o
);
	if (DATA_WIDTH != 8 || BUFFER_DEPTH < 2) begin : g_bad_params
		$error("hcl_crc_count_loopback: byte-wide data and a buffer of at least 2 required");
	end

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
		return addr == offset;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] test_ctrl_reg, test_ctrl_next;
	logic zero_seen_reg, zero_seen_next;
	logic [7:0] count_reg, count_next;
	logic [7:0] length_reg, length_next;
	logic [7:0] check_high_reg, check_high_next;
	logic [7:0] check_low_reg, check_low_next;
	logic [7:0] hold_reg [0:hcl_pkg::HOLD_DEPTH-1];
	logic [7:0] hold_next [0:hcl_pkg::HOLD_DEPTH-1];
	logic [1:0] hold_cnt_reg, hold_cnt_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [1:0] tag_rb_reg, tag_rb_next;

	logic soft_reset, int_rst_n, rt_loop, fifo_test, tr_loop;
	logic wr_take, rd_take, host_fifo_wr, host_fifo_rd;
	logic rx_take, emit, emit_pending, count_last;
	logic [hcl_pkg::WORD_W-1:0] emit_word, host_word;

	hcl_stream_if #(.WIDTH(hcl_pkg::WORD_W)) tx_in_if ();
	hcl_stream_if #(.WIDTH(hcl_pkg::WORD_W)) tx_out_if ();
	hcl_stream_if #(.WIDTH(hcl_pkg::WORD_W)) rx_in_if ();
	hcl_stream_if #(.WIDTH(hcl_pkg::WORD_W)) rx_out_if ();

	////////////////////////////////////////////////////////////////////////
	// Control bits and strobes
	assign soft_reset = test_ctrl_reg[hcl_pkg::LINK_SOFT_RESET_BIT];
	// Controller state is cleared by either reset source
	assign int_rst_n = rst_n_i && !soft_reset;
	assign rt_loop = test_ctrl_reg[hcl_pkg::RX_TO_TX_LOOPBACK_BIT];
	assign fifo_test = test_ctrl_reg[hcl_pkg::FIFO_TEST_BIT];
	assign tr_loop = test_ctrl_reg[hcl_pkg::TX_TO_RX_LOOPBACK_BIT];
	assign link_soft_reset_o = soft_reset;

	// Serial path only; the receiver still needs its own enable set
	assign rx_serial_o = tr_loop ? tx_serial_i : line_rx_i;

	// Strobes count only while enabled, else a FIFO pop would lose its data
	assign wr_take = ce_i && cs_i && wr_i;
	assign rd_take = ce_i && cs_i && rd_i;
	assign count_last = (count_reg == hcl_pkg::TX_LENGTH_LAST);

	////////////////////////////////////////////////////////////////////////
	// Receive path: the last two bytes before the closing flag are the check,
	// so three bytes are held back before one is released as data.
	assign rx_ready_o = !soft_reset && rx_in_if.ready && (!rt_loop || tx_in_if.ready);
	assign rx_take = rx_valid_i && rx_ready_o;
	assign emit_pending = rx_valid_i && (hold_cnt_reg == hcl_pkg::HOLD_COUNT_FULL);
	assign emit = rx_take && (hold_cnt_reg == hcl_pkg::HOLD_COUNT_FULL);

	always_comb begin
		emit_word = '0;
		emit_word[7:0] = hold_reg[hcl_pkg::HOLD_DEPTH-1];
		emit_word[8 + hcl_pkg::PACKET_END_TAG_POS] = rx_last_i;
		emit_word[8 + hcl_pkg::FRAME_ABORT_TAG_POS] = rx_last_i && rx_abort_i;
	end

	always_comb begin
		for (int i = 0; i < hcl_pkg::HOLD_DEPTH; i++) begin
			hold_next[i] = hold_reg[i];
		end
		hold_cnt_next = hold_cnt_reg;
		check_high_next = check_high_reg;
		check_low_next = check_low_reg;
		if (rx_take) begin
			if (rx_last_i) begin
				// Bytes kept exactly as assembled, first bit in bit 7
				check_high_next = hold_reg[1];
				check_low_next = hold_reg[0];
				hold_cnt_next = hcl_pkg::HOLD_COUNT_RESET;
				for (int i = 0; i < hcl_pkg::HOLD_DEPTH; i++) begin
					hold_next[i] = '0;
				end
			end else begin
				hold_next[0] = rx_byte_i;
				for (int i = 1; i < hcl_pkg::HOLD_DEPTH; i++) begin
					hold_next[i] = hold_reg[i-1];
				end
				if (hold_cnt_reg != hcl_pkg::HOLD_COUNT_FULL) begin
					hold_cnt_next = hold_cnt_reg + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!int_rst_n) begin
			hold_cnt_reg <= hcl_pkg::HOLD_COUNT_RESET;
			check_high_reg <= hcl_pkg::RX_CHECK_RESET;
			check_low_reg <= hcl_pkg::RX_CHECK_RESET;
			for (int i = 0; i < hcl_pkg::HOLD_DEPTH; i++) begin
				hold_reg[i] <= '0;
			end
		end else if (ce_i) begin
			hold_cnt_reg <= hold_cnt_next;
			check_high_reg <= check_high_next;
			check_low_reg <= check_low_next;
			hold_reg <= hold_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host FIFO access; the receiver wins a shared buffer input
	always_comb begin
		host_word = '0;
		host_word[7:0] = wdata_i;
		// Count tagging only on genuine transmit writes
		host_word[8 + hcl_pkg::PACKET_END_TAG_POS] = packet_end_tag_i || (count_last && !fifo_test);
		host_word[8 + hcl_pkg::FRAME_ABORT_TAG_POS] = frame_abort_tag_i;
	end

	always_comb begin
		if (soft_reset) begin
			host_wait_o = 1'b1;
		end else if (fifo_test) begin
			host_wait_o = emit_pending || !rx_in_if.ready;
		end else begin
			host_wait_o = (emit_pending && rt_loop) || !tx_in_if.ready;
		end
	end

	assign host_fifo_wr = wr_take && reg_hit(addr_i, hcl_pkg::FIFO_DATA_ADDR) && !host_wait_o;
	assign host_fifo_rd = rd_take && reg_hit(addr_i, hcl_pkg::FIFO_DATA_ADDR) && !soft_reset;
	// Reads pop the transmit FIFO in test mode
	assign txf_rd_o = host_fifo_rd && fifo_test;
	assign rxf_rd_o = host_fifo_rd && !fifo_test;

	// Receive buffer: received data, or host writes in test mode
	assign rx_in_if.valid = emit || (host_fifo_wr && fifo_test);
	assign rx_in_if.data = emit ? emit_word : host_word;
	// Transmit buffer: looped data treated like host data, good or bad
	assign tx_in_if.valid = (emit && rt_loop) || (host_fifo_wr && !fifo_test);
	assign tx_in_if.data = (emit && rt_loop) ? emit_word : host_word;

	hcl_pair_buffer #(
		.WIDTH(hcl_pkg::WORD_W),
		.DEPTH(BUFFER_DEPTH)
	) u_tx_buffer (
		.mclk_i(mclk_i),
		.rst_n_i(int_rst_n),
		.ce_i(ce_i),
		.in_if(tx_in_if.snk),
		.out_if(tx_out_if.src)
	);

	hcl_pair_buffer #(
		.WIDTH(hcl_pkg::WORD_W),
		.DEPTH(BUFFER_DEPTH)
	) u_rx_buffer (
		.mclk_i(mclk_i),
		.rst_n_i(int_rst_n),
		.ce_i(ce_i),
		.in_if(rx_in_if.snk),
		.out_if(rx_out_if.src)
	);

	assign txf_wr_valid_o = tx_out_if.valid;
	assign txf_wr_data_o = tx_out_if.data[7:0];
	assign txf_wr_tags_o = tx_out_if.data[hcl_pkg::WORD_W-1:8];
	assign tx_out_if.ready = txf_wr_ready_i;
	assign rxf_wr_valid_o = rx_out_if.valid;
	assign rxf_wr_data_o = rx_out_if.data[7:0];
	assign rxf_wr_tags_o = rx_out_if.data[hcl_pkg::WORD_W-1:8];
	assign rx_out_if.ready = rxf_wr_ready_i;

	////////////////////////////////////////////////////////////////////////
	// Transmit length counter
	always_comb begin
		count_next = count_reg;
		length_next = length_reg;
		if (wr_take && reg_hit(addr_i, hcl_pkg::TX_PACKET_LENGTH_COUNTER_ADDR)) begin
			count_next = wdata_i;
			length_next = wdata_i;
		end else if (host_fifo_wr && !fifo_test) begin
			if (count_last) begin
				count_next = auto_repeat_i ? length_reg : 8'h00;
			end else if (count_reg != 8'h00) begin
				count_next = count_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!int_rst_n) begin
			count_reg <= hcl_pkg::TX_LENGTH_COUNT_RESET;
			length_reg <= hcl_pkg::TX_LENGTH_COUNT_RESET;
		end else if (ce_i) begin
			count_reg <= count_next;
			length_reg <= length_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Test control; only the hardware reset clears it outright
	always_comb begin
		test_ctrl_next = test_ctrl_reg;
		zero_seen_next = zero_seen_reg;
		if (wr_take && reg_hit(addr_i, hcl_pkg::LINK_TEST_CONTROL_ADDR)) begin
			test_ctrl_next = wdata_i;
			if (soft_reset && !wdata_i[hcl_pkg::LINK_SOFT_RESET_BIT]) begin
				// First zero write keeps reset, second one releases it
				test_ctrl_next[hcl_pkg::LINK_SOFT_RESET_BIT] = zero_seen_reg ? 1'b0 : 1'b1;
				zero_seen_next = !zero_seen_reg;
			end else begin
				zero_seen_next = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			test_ctrl_reg <= hcl_pkg::LINK_TEST_CONTROL_RESET;
			zero_seen_reg <= 1'b0;
		end else if (ce_i) begin
			test_ctrl_reg <= test_ctrl_next;
			zero_seen_reg <= zero_seen_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; check bytes have no write path
	always_comb begin
		rdata_next = rdata_reg;
		tag_rb_next = tag_rb_reg;
		if (rd_take) begin
			rdata_next = hcl_pkg::READ_DATA_RESET;
			if (reg_hit(addr_i, hcl_pkg::RX_CHECK_HIGH_BYTE_ADDR)) begin
				rdata_next = check_high_reg;
			end else if (reg_hit(addr_i, hcl_pkg::RX_CHECK_LOW_BYTE_ADDR)) begin
				rdata_next = check_low_reg;
			end else if (reg_hit(addr_i, hcl_pkg::TX_PACKET_LENGTH_COUNTER_ADDR)) begin
				rdata_next = count_reg;
			end else if (reg_hit(addr_i, hcl_pkg::LINK_TEST_CONTROL_ADDR)) begin
				rdata_next = test_ctrl_reg;
			end else if (host_fifo_rd) begin
				rdata_next = fifo_test ? txf_rd_data_i : rxf_rd_data_i;
				tag_rb_next = fifo_test ? txf_rd_tags_i : rxf_rd_tags_i;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= hcl_pkg::READ_DATA_RESET;
			tag_rb_reg <= 2'h0;
		end else if (ce_i) begin
			rdata_reg <= rdata_next;
			tag_rb_reg <= tag_rb_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign fifo_tag_readback_o = tag_rb_reg;
endmodule

// ==== bench/hcl_crc_count_loopback_sva.sv ====
// Checker for the check capture, length counter and test control block
`timescale 1ns/10ps
module hcl_crc_count_loopback_sva (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic ce_i,
	input wire logic cs_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] fifo_tag_readback_o,
	input wire logic host_wait_o,
	input wire logic link_soft_reset_o,
	// Streams, FIFO ports, serial
	input wire logic rx_ready_o,
	input wire logic rxf_wr_valid_o,
	input wire logic txf_rd_o,
	input wire logic rxf_rd_o,
	input wire logic [7:0] txf_rd_data_i,
	input wire logic [1:0] txf_rd_tags_i,
	input wire logic tx_serial_i,
	input wire logic line_rx_i,
	input wire logic rx_serial_o
);
	logic wr_tc;
	logic fifo_wr;
	logic fifo_rd;
	logic [7:0] tc_reg;
	logic [7:0] tc_next;
	logic zc_reg;
	logic zc_next;
	assign wr_tc = ce_i && cs_i && wr_i && addr_i == hcl_pkg::LINK_TEST_CONTROL_ADDR;
	assign fifo_wr = ce_i && cs_i && wr_i && addr_i == hcl_pkg::FIFO_DATA_ADDR && !host_wait_o;
	assign fifo_rd = ce_i && cs_i && rd_i && addr_i == hcl_pkg::FIFO_DATA_ADDR && !link_soft_reset_o;

	// Shadow of test control; soft reset leaves it, so only hardware reset clears it
	always_comb begin
		tc_next = tc_reg;
		zc_next = zc_reg;
		if (wr_tc) begin
			tc_next = wdata_i;
			zc_next = !wdata_i[7] && link_soft_reset_o && !zc_reg;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tc_reg <= 8'h00;
			zc_reg <= 1'b0;
		end else begin
			tc_reg <= tc_next;
			zc_reg <= zc_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_soft_set: assert property (wr_tc && wdata_i[7] |=> link_soft_reset_o)
		else $error("soft reset bit not set");
	a_soft_blocks: assert property (link_soft_reset_o |-> !rx_ready_o && host_wait_o && !txf_rd_o && !rxf_rd_o)
		else $error("controller active in soft reset");
	a_soft_first_zero: assert property (wr_tc && !wdata_i[7] && link_soft_reset_o && !zc_reg |=> link_soft_reset_o)
		else $error("soft reset cleared by one zero write");
	a_soft_second_zero: assert property (wr_tc && !wdata_i[7] && zc_reg |=> !link_soft_reset_o)
		else $error("soft reset kept after two zero writes");
	a_loop_mux: assert property (rx_serial_o == (tc_reg[0] ? tx_serial_i : line_rx_i))
		else $error("receive input source wrong");
	a_fifo_swap_read: assert property (fifo_rd |-> txf_rd_o == tc_reg[2] && rxf_rd_o == !tc_reg[2])
		else $error("wrong FIFO popped");
	a_fifo_swap_write: assert property (tc_reg[2] && fifo_wr |=> !ce_i || rxf_wr_valid_o)
		else $error("test write missed receive path");
	a_tag_readback: assert property (tc_reg[2] && fifo_rd |=> fifo_tag_readback_o == $past(txf_rd_tags_i)
		&& rdata_o == $past(txf_rd_data_i))
		else $error("transmit head not returned");
endmodule

bind hcl_crc_count_loopback hcl_crc_count_loopback_sva i_sva (.mclk_i, .rst_n_i, .ce_i, .cs_i, .rd_i, .wr_i,
	.addr_i, .wdata_i, .rdata_o, .fifo_tag_readback_o, .host_wait_o, .link_soft_reset_o, .rx_ready_o,
	.rxf_wr_valid_o, .txf_rd_o, .rxf_rd_o, .txf_rd_data_i, .txf_rd_tags_i, .tx_serial_i, .line_rx_i, .rx_serial_o);

// ==== bench/hcl_far_model.sv ====
// Far side: deframer beat source, FIFO write sinks and FIFO read heads
`timescale 1ns/10ps
module hcl_far_model #(
	parameter logic [7:0] HEAD_TX = 8'h00,
	parameter logic [7:0] HEAD_RX = 8'h00
) (
	// Clock, reset, stall
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	// Receive beats
	output logic rv_o = 1'b0,
	output logic [7:0] rb_o = 8'h00,
	output logic rl_o = 1'b0,
	output logic ra_o = 1'b0,
	input wire logic rr_i,
	// FIFO sinks and heads
	input wire logic tv_i,
	input wire logic [9:0] tw_i,
	output logic tr_o,
	input wire logic qv_i,
	input wire logic [9:0] qw_i,
	output logic qr_o,
	output logic [9:0] th_o,
	output logic [9:0] qh_o
);
	logic [9:0] txq[$];
	logic [9:0] rxq[$];
	assign tr_o = !stall_i;
	assign qr_o = !stall_i;
	assign th_o = {2'h2, HEAD_TX};
	assign qh_o = {2'h1, HEAD_RX};
	always @(posedge mclk_i) begin
		if (rst_n_i && tv_i && tr_o)
			txq.push_back(tw_i);
		if (rst_n_i && qv_i && qr_o)
			rxq.push_back(qw_i);
	end

	////////////////////////////////////////////////////////////////////////
	task automatic beat(input logic [7:0] b, input logic l, input logic ab);
		int k;
		@(posedge mclk_i);
		rv_o <= 1'b1;
		rb_o <= b;
		rl_o <= l;
		ra_o <= ab;
		k = 0;
		do begin
			@(negedge mclk_i);
			k++;
		end while (rr_i !== 1'b1 && k < 300);
		@(posedge mclk_i);
		rv_o <= 1'b0;
		// Stale byte is inverted so nothing downstream can lean on it
		rb_o <= ~b;
		rl_o <= 1'b0;
		ra_o <= 1'b0;
	endtask
	task automatic packet(input logic [7:0] first, input int len, input logic ab);
		for (int i = 0; i < len; i++)
			beat(first + 8'(i), 1'b0, 1'b0);
		beat(8'h00, 1'b1, ab);
	endtask
endmodule

// ==== bench/tb_hcl_crc_count_loopback.sv ====
// Testbench: register access, packet capture, counter and loopback tests
`timescale 1ns/10ps
module tb_hcl_crc_count_loopback;
	localparam logic [7:0] HEAD_TX = 8'h96;
	localparam logic [7:0] HEAD_RX = 8'h69;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, cs_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, stall = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rx_byte_i;
	logic auto_repeat_i = 1'b0, packet_end_tag_i = 1'b0, frame_abort_tag_i = 1'b0;
	logic tx_serial_i = 1'b0, line_rx_i = 1'b0, rx_serial_o, host_wait_o, link_soft_reset_o;
	logic rx_valid_i, rx_last_i, rx_abort_i, rx_ready_o, txf_wr_valid_o, txf_wr_ready_i, txf_rd_o;
	logic rxf_wr_valid_o, rxf_wr_ready_i, rxf_rd_o;
	logic [7:0] txf_wr_data_o, txf_rd_data_i, rxf_wr_data_o, rxf_rd_data_i;
	logic [1:0] fifo_tag_readback_o, txf_wr_tags_o, txf_rd_tags_i, rxf_wr_tags_o, rxf_rd_tags_i;
	int bad_count = 0, checks_done = 0, cycles = 0;

	hcl_crc_count_loopback i_dut (.mclk_i, .rst_n_i, .ce_i, .cs_i, .rd_i, .wr_i, .addr_i, .wdata_i, .rdata_o,
		.fifo_tag_readback_o, .host_wait_o, .auto_repeat_i, .packet_end_tag_i, .frame_abort_tag_i,
		.link_soft_reset_o, .rx_valid_i, .rx_byte_i, .rx_last_i, .rx_abort_i, .rx_ready_o, .txf_wr_valid_o,
		.txf_wr_data_o, .txf_wr_tags_o, .txf_wr_ready_i, .txf_rd_o, .txf_rd_data_i, .txf_rd_tags_i,
		.rxf_wr_valid_o, .rxf_wr_data_o, .rxf_wr_tags_o, .rxf_wr_ready_i, .rxf_rd_o, .rxf_rd_data_i,
		.rxf_rd_tags_i, .tx_serial_i, .line_rx_i, .rx_serial_o);
	hcl_far_model #(.HEAD_TX(HEAD_TX), .HEAD_RX(HEAD_RX)) i_far (.mclk_i, .rst_n_i, .stall_i(stall),
		.rv_o(rx_valid_i), .rb_o(rx_byte_i), .rl_o(rx_last_i), .ra_o(rx_abort_i), .rr_i(rx_ready_o),
		.tv_i(txf_wr_valid_o), .tw_i({txf_wr_tags_o, txf_wr_data_o}), .tr_o(txf_wr_ready_i),
		.qv_i(rxf_wr_valid_o), .qw_i({rxf_wr_tags_o, rxf_wr_data_o}), .qr_o(rxf_wr_ready_i),
		.th_o({txf_rd_tags_i, txf_rd_data_i}), .qh_o({rxf_rd_tags_i, rxf_rd_data_i}));

	always #20 mclk_i = ~mclk_i;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge mclk_i);
		cs_i <= 1'b1;
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		k = 0;
		// A FIFO write refused by the wait line is held until taken
		do begin
			@(negedge mclk_i);
			k++;
		end while (host_wait_o === 1'b1 && a == hcl_pkg::FIFO_DATA_ADDR && k < 200);
		@(posedge mclk_i);
		cs_i <= 1'b0;
		wr_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		cs_i <= 1'b1;
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		cs_i <= 1'b0;
		rd_i <= 1'b0;
		@(negedge mclk_i);
		chk({2'h0, rdata_o}, {2'h0, exp});
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	initial begin
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		for (int a = 8'h18; a < 8'h1c; a++)
			rd_chk(8'(a), 8'h00);
		i_far.packet(8'hc0, 5, 1'b0);
		repeat (4) @(posedge mclk_i);
		rd_chk(8'h18, 8'hc3);
		rd_chk(8'h19, 8'hc4);
		chk(10'(i_far.rxq.size()), 10'h003);
		for (int i = 0; i < 3; i++)
			chk(i_far.rxq.pop_front(), {1'b0, i == 2, 8'(8'hc0 + i)});
		wr_reg(8'h18, 8'hff);
		wr_reg(8'h19, 8'hff);
		rd_chk(8'h18, 8'hc3);
		rd_chk(8'h19, 8'hc4);
		@(posedge mclk_i);
		stall <= 1'b1;
		fork
			i_far.packet(8'h10, 6, 1'b1);
			begin
				repeat (30) @(posedge mclk_i);
				@(negedge mclk_i);
				chk(rx_ready_o, 1'b0);
				rd_chk(8'h18, 8'hc3);
				@(posedge mclk_i);
				stall <= 1'b0;
			end
		join
		repeat (6) @(posedge mclk_i);
		rd_chk(8'h18, 8'h14);
		rd_chk(8'h19, 8'h15);
		for (int i = 0; i < 4; i++)
			chk(i_far.rxq.pop_front(), {i == 3, i == 3, 8'(8'h10 + i)});
		wr_reg(8'h1b, 8'h40);
		i_far.packet(8'ha0, 4, 1'b0);
		repeat (6) @(posedge mclk_i);
		chk(10'(i_far.txq.size()), 10'h002);
		for (int i = 0; i < 2; i++) begin
			chk(i_far.txq.pop_front(), {1'b0, i == 1, 8'(8'ha0 + i)});
			chk(i_far.rxq.pop_front(), {1'b0, i == 1, 8'(8'ha0 + i)});
		end
		wr_reg(8'h1b, 8'h00);
		wr_reg(8'h1a, 8'h03);
		for (int i = 0; i < 3; i++)
			wr_reg(hcl_pkg::FIFO_DATA_ADDR, 8'(i));
		rd_chk(8'h1a, 8'h00);
		wr_reg(8'h1a, 8'h02);
		auto_repeat_i <= 1'b1;
		for (int i = 3; i < 7; i++)
			wr_reg(hcl_pkg::FIFO_DATA_ADDR, 8'(i));
		rd_chk(8'h1a, 8'h02);
		wr_reg(hcl_pkg::FIFO_DATA_ADDR, 8'h07);
		// A load while the enable is low must not land
		ce_i <= 1'b0;
		wr_reg(8'h1a, 8'h55);
		ce_i <= 1'b1;
		rd_chk(8'h1a, 8'h01);
		repeat (4) @(posedge mclk_i);
		chk(10'(i_far.txq.size()), 10'h008);
		for (int i = 0; i < 8; i++)
			chk(i_far.txq.pop_front(), {1'b0, i == 2 || i == 4 || i == 6, 8'(i)});
		wr_reg(8'h1b, 8'h04);
		packet_end_tag_i <= 1'b1;
		frame_abort_tag_i <= 1'b1;
		wr_reg(hcl_pkg::FIFO_DATA_ADDR, 8'h5e);
		rd_chk(hcl_pkg::FIFO_DATA_ADDR, HEAD_TX);
		chk(fifo_tag_readback_o, 2'h2);
		chk(i_far.rxq.pop_front(), 10'h35e);
		chk(10'(i_far.txq.size()), 10'h000);
		wr_reg(8'h1b, 8'h00);
		packet_end_tag_i <= 1'b0;
		frame_abort_tag_i <= 1'b0;
		rd_chk(hcl_pkg::FIFO_DATA_ADDR, HEAD_RX);
		chk(fifo_tag_readback_o, 2'h1);
		wr_reg(8'h1b, 8'h01);
		tx_serial_i <= 1'b1;
		@(negedge mclk_i);
		chk(rx_serial_o, 1'b1);
		wr_reg(8'h1b, 8'h00);
		@(negedge mclk_i);
		chk(rx_serial_o, 1'b0);
		wr_reg(8'h1b, 8'h80);
		@(negedge mclk_i);
		chk({link_soft_reset_o, rx_ready_o, host_wait_o}, 3'b101);
		rd_chk(8'h18, 8'h00);
		rd_chk(8'h1a, 8'h00);
		wr_reg(8'h1b, 8'h00);
		@(negedge mclk_i);
		chk(link_soft_reset_o, 1'b1);
		wr_reg(8'h1b, 8'h00);
		@(negedge mclk_i);
		chk({link_soft_reset_o, rx_ready_o, host_wait_o}, 3'b010);
		wrap_up();
	end
endmodule
